// file: fpio_defines.svh
// Named constants of the four-port parallel I/O block: offsets, widths, bits.
// Assumes inclusion by bare name from every design file of the block.
`ifndef FPIO_DEFINES_SVH
`define FPIO_DEFINES_SVH

// ------------------------------------------------------------------
// Bus and port widths
// ------------------------------------------------------------------
`define FPIO_ADDR_W 8
`define FPIO_DATA_W 8
`define FPIO_PA_W 8
`define FPIO_PB_W 6
`define FPIO_PC_W 8
`define FPIO_PD_W 4

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define FPIO_OFS_PA_DATA 8'h00
`define FPIO_OFS_PB_DATA 8'h01
`define FPIO_OFS_PC_DATA 8'h02
`define FPIO_OFS_PD_DATA 8'h03
`define FPIO_OFS_PA_DIR 8'h04
`define FPIO_OFS_PB_DIR 8'h05
`define FPIO_OFS_PC_DIR 8'h06
`define FPIO_OFS_PD_DIR 8'h07

// ------------------------------------------------------------------
// Reset values and pin attributes
// ------------------------------------------------------------------
`define FPIO_DIR_RST 8'h00
`define FPIO_RDATA_RST 8'h00
`define FPIO_PB_OD_MASK 6'h3C
`define FPIO_PD_OD_MASK 4'hF
`define FPIO_PC_PWM_OD_MASK 8'h03

// ------------------------------------------------------------------
// Shared-pin bit positions
// ------------------------------------------------------------------
`define FPIO_PC_VSYNC_BIT 6
`define FPIO_PC_HSYNC_BIT 7
`define FPIO_PC_ADC_LO_BIT 2
`define FPIO_PC_ADC_HI_BIT 5
`define FPIO_PD_SCL_BIT 0
`define FPIO_PD_SDA_BIT 1
`define FPIO_PD_CLAMP_BIT 2
`define FPIO_PD_SOG_BIT 3

`endif

// file: fpio_pkg.sv
// Types of the four-port parallel I/O block.
// Assumes fpio_defines.svh for the numeric constants.
package fpio_pkg;

    // ------------------------------------------------------------------
    // Function that owns a port C pin, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        FPIO_FN_GPIO = 4'h1,
        FPIO_FN_PWM = 4'h2,
        FPIO_FN_SYNC = 4'h4,
        FPIO_FN_ADC = 4'h8
    } fpio_func_e;

endpackage

// file: fpio_pin_cell.sv
// Output stage of one port: merges latch, direction and peripheral drive.
// Assumes the caller supplies peripheral ownership per bit; outputs are flops.
`timescale 1ns/1ps
`include "fpio_defines.svh"

module fpio_pin_cell import fpio_pkg::*; #(
    parameter int WIDTH = `FPIO_DATA_W
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic [WIDTH-1:0] i_latch,
    input wire logic [WIDTH-1:0] i_dir,
    input wire logic [WIDTH-1:0] i_gpio_od,
    input wire logic [WIDTH-1:0] i_own,
    input wire logic [WIDTH-1:0] i_per_oe,
    input wire logic [WIDTH-1:0] i_per_val,
    input wire logic [WIDTH-1:0] i_per_od,
    output logic [WIDTH-1:0] o_out,
    output logic [WIDTH-1:0] o_oe
);

    logic [WIDTH-1:0] nxt_out;
    logic [WIDTH-1:0] nxt_oe;

    // ------------------------------------------------------------------
    // Per-bit drive selection
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic drive;
            logic val;
            logic od;
            // Peripheral wins over direction bit when it owns the pin
            assign drive = i_own[gi] ? i_per_oe[gi] : i_dir[gi];
            assign val = i_own[gi] ? i_per_val[gi] : i_latch[gi];
            assign od = i_own[gi] ? i_per_od[gi] : i_gpio_od[gi];
            // Open drain only pulls low; a high level is left to the pull-up
            assign nxt_oe[gi] = od ? (drive & ~val) : drive;
            assign nxt_out[gi] = od ? 1'h0 : val;
        end
    endgenerate

    // Registered pins; released while reset holds so all pins are inputs
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_out <= '0;
            o_oe <= '0;
        end else begin
            o_out <= nxt_out;
            o_oe <= nxt_oe;
        end
    end

endmodule

// file: fpio_pc_mux.sv
// Port C function selection from the two configuration registers.
// Assumes configuration bits and peripheral outputs arrive as levels.
`timescale 1ns/1ps
`include "fpio_defines.svh"

module fpio_pc_mux import fpio_pkg::*; (
    input wire logic [`FPIO_PC_W-1:0] i_pwm_sel,
    input wire logic [`FPIO_PC_W-1:0] i_pwm_val,
    input wire logic i_vsync_sel,
    input wire logic i_hsync_sel,
    input wire logic i_vertical_sync_out,
    input wire logic i_horizontal_sync_out,
    input wire logic [`FPIO_PC_ADC_HI_BIT-`FPIO_PC_ADC_LO_BIT:0] i_adc_sel,
    output logic [`FPIO_PC_W-1:0] o_own,
    output logic [`FPIO_PC_W-1:0] o_per_oe,
    output logic [`FPIO_PC_W-1:0] o_per_val,
    output logic [`FPIO_PC_W-1:0] o_per_od
);

    // Per-pin open-drain attribute of the PWM channels, indexable by bit
    localparam logic [`FPIO_PC_W-1:0] PWM_OD = `FPIO_PC_PWM_OD_MASK;

    // ------------------------------------------------------------------
    // One function decision per pin
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `FPIO_PC_W; gi++) begin : g_bit
            fpio_func_e func;
            logic sync_hit;
            logic sync_val;
            logic adc_hit;
            if (gi == `FPIO_PC_VSYNC_BIT) begin : g_vs
                assign sync_hit = i_vsync_sel;
                assign sync_val = i_vertical_sync_out;
            end else if (gi == `FPIO_PC_HSYNC_BIT) begin : g_hs
                assign sync_hit = i_hsync_sel;
                assign sync_val = i_horizontal_sync_out;
            end else begin : g_nosync
                assign sync_hit = 1'h0;
                assign sync_val = 1'h0;
            end
            if (gi >= `FPIO_PC_ADC_LO_BIT && gi <= `FPIO_PC_ADC_HI_BIT) begin : g_adc
                assign adc_hit = i_adc_sel[gi-`FPIO_PC_ADC_LO_BIT];
            end else begin : g_noadc
                assign adc_hit = 1'h0;
            end
            // Second register checked last so it overrides the first
            always_comb begin
                func = FPIO_FN_GPIO;
                if (i_pwm_sel[gi]) begin
                    func = FPIO_FN_PWM;
                end
                if (sync_hit) begin
                    func = FPIO_FN_SYNC;
                end else if (adc_hit) begin
                    func = FPIO_FN_ADC;
                end
            end
            // Drive per function; PWM is output only, ADC leaves pin floating
            always_comb begin
                case (func)
                    FPIO_FN_PWM: begin
                        o_own[gi] = 1'h1;
                        o_per_oe[gi] = 1'h1;
                        o_per_val[gi] = i_pwm_val[gi];
                        o_per_od[gi] = PWM_OD[gi];
                    end
                    FPIO_FN_SYNC: begin
                        o_own[gi] = 1'h1;
                        o_per_oe[gi] = 1'h1;
                        o_per_val[gi] = sync_val;
                        o_per_od[gi] = 1'h0;
                    end
                    FPIO_FN_ADC: begin
                        o_own[gi] = 1'h1;
                        o_per_oe[gi] = 1'h0;
                        o_per_val[gi] = 1'h0;
                        o_per_od[gi] = 1'h0;
                    end
                    default: begin
                        o_own[gi] = 1'h0;
                        o_per_oe[gi] = 1'h0;
                        o_per_val[gi] = 1'h0;
                        o_per_od[gi] = 1'h0;
                    end
                endcase
            end
        end
    endgenerate

endmodule

// file: fpio_top.sv
// Four-port parallel I/O: data latches, direction registers, pin sharing.
// Assumes a synchronous CPU bus, pins sampled on i_clk_sys, and the
// configuration bits held by other modules arriving as plain levels.
//
// Functional notes
// - Port A: eight pins, data at 0x00, direction at 0x04.
// - Port B: six pins, data at 0x01, direction at 0x05.
// - Port C: eight pins, data at 0x02, direction at 0x06.
// - Port D: four pins, data at 0x03, direction at 0x07.
// - Reset clears all direction registers, making every pin an input.
// - Reset leaves the data latches untouched.
// - Direction one means output, zero means input, per pin.
// - Output pins read back the latch, not the pin.
// - Input pins read back the pin level.
// - Writes always load the latch; it drives only when direction is one.
// - Port C pin carries its PWM channel when first config bit is set.
// - Port C bits 6 and 7 become vertical and horizontal sync outputs.
// - Port C bits 2 to 5 become converter inputs when selected.
// - Second config register wins over first on conflicts.
// - Port D bits 0 and 1 become open-drain serial clock and data.
// - Port D bit 2 is open drain and carries clamp when selected.
// - Port D bit 3 is open drain and feeds sync-on-green when selected.
// - Port B bits 2 to 5 only pull low.
// - A selected peripheral owns its port D pin regardless of direction.
// - A PWM-assigned port C pin is output only.
`timescale 1ns/1ps
`include "fpio_defines.svh"

module fpio_top import fpio_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // CPU bus
    input wire logic [`FPIO_ADDR_W-1:0] i_bus_addr,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    input wire logic [`FPIO_DATA_W-1:0] i_bus_wdata,
    output logic [`FPIO_DATA_W-1:0] o_bus_rdata,
    // Configuration levels from other modules
    input wire logic [`FPIO_PC_W-1:0] i_cfg1_pwm_sel,
    input wire logic i_cfg2_vsync_sel,
    input wire logic i_cfg2_hsync_sel,
    input wire logic [`FPIO_PC_ADC_HI_BIT-`FPIO_PC_ADC_LO_BIT:0] i_cfg2_adc_sel,
    input wire logic i_cfg2_scl_sel,
    input wire logic i_cfg2_sda_sel,
    input wire logic i_clamp_sel,
    input wire logic i_sog_sel,
    // Peripheral signals
    input wire logic [`FPIO_PC_W-1:0] i_pwm_val,
    input wire logic i_vertical_sync_out,
    input wire logic i_horizontal_sync_out,
    input wire logic i_scl_drive_low,
    input wire logic i_sda_drive_low,
    input wire logic i_clamp_val,
    output logic o_scl_in,
    output logic o_sda_in,
    output logic o_sync_on_green_input,
    // Pins
    input wire logic [`FPIO_PA_W-1:0] i_pa_pin,
    output logic [`FPIO_PA_W-1:0] o_pa_out,
    output logic [`FPIO_PA_W-1:0] o_pa_oe,
    input wire logic [`FPIO_PB_W-1:0] i_pb_pin,
    output logic [`FPIO_PB_W-1:0] o_pb_out,
    output logic [`FPIO_PB_W-1:0] o_pb_oe,
    input wire logic [`FPIO_PC_W-1:0] i_pc_pin,
    output logic [`FPIO_PC_W-1:0] o_pc_out,
    output logic [`FPIO_PC_W-1:0] o_pc_oe,
    input wire logic [`FPIO_PD_W-1:0] i_pd_pin,
    output logic [`FPIO_PD_W-1:0] o_pd_out,
    output logic [`FPIO_PD_W-1:0] o_pd_oe
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [`FPIO_PA_W-1:0] port_a_data_ff;
    logic [`FPIO_PB_W-1:0] port_b_data_ff;
    logic [`FPIO_PC_W-1:0] port_c_data_ff;
    logic [`FPIO_PD_W-1:0] port_d_data_ff;
    logic [`FPIO_PA_W-1:0] port_a_direction_ff;
    logic [`FPIO_PB_W-1:0] port_b_direction_ff;
    logic [`FPIO_PC_W-1:0] port_c_direction_ff;
    logic [`FPIO_PD_W-1:0] port_d_direction_ff;

    logic [`FPIO_DATA_W-1:0] nxt_rdata;
    logic [`FPIO_PA_W-1:0] rd_a;
    logic [`FPIO_PB_W-1:0] rd_b;
    logic [`FPIO_PC_W-1:0] rd_c;
    logic [`FPIO_PD_W-1:0] rd_d;

    logic [`FPIO_PC_W-1:0] pc_own;
    logic [`FPIO_PC_W-1:0] pc_per_oe;
    logic [`FPIO_PC_W-1:0] pc_per_val;
    logic [`FPIO_PC_W-1:0] pc_per_od;
    logic [`FPIO_PD_W-1:0] pd_own;
    logic [`FPIO_PD_W-1:0] pd_per_oe;
    logic [`FPIO_PD_W-1:0] pd_per_val;

    logic sel_pa_data;
    logic sel_pb_data;
    logic sel_pc_data;
    logic sel_pd_data;
    logic sel_pa_dir;
    logic sel_pb_dir;
    logic sel_pc_dir;
    logic sel_pd_dir;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------

    // Full-width compare so aliases of the eight locations stay unmapped
    assign sel_pa_data = (i_bus_addr == `FPIO_OFS_PA_DATA);
    assign sel_pb_data = (i_bus_addr == `FPIO_OFS_PB_DATA);
    assign sel_pc_data = (i_bus_addr == `FPIO_OFS_PC_DATA);
    assign sel_pd_data = (i_bus_addr == `FPIO_OFS_PD_DATA);
    assign sel_pa_dir = (i_bus_addr == `FPIO_OFS_PA_DIR);
    assign sel_pb_dir = (i_bus_addr == `FPIO_OFS_PB_DIR);
    assign sel_pc_dir = (i_bus_addr == `FPIO_OFS_PC_DIR);
    assign sel_pd_dir = (i_bus_addr == `FPIO_OFS_PD_DIR);

    // ------------------------------------------------------------------
    // Data latches
    // ------------------------------------------------------------------

    // No reset term: latch contents survive reset so software can
    // preload them before the pins are turned to outputs
    always_ff @(posedge i_clk_sys) begin
        if (i_bus_wr && sel_pa_data) begin
            port_a_data_ff <= i_bus_wdata;
        end
        if (i_bus_wr && sel_pb_data) begin
            port_b_data_ff <= i_bus_wdata[`FPIO_PB_W-1:0];
        end
        if (i_bus_wr && sel_pc_data) begin
            port_c_data_ff <= i_bus_wdata;
        end
        if (i_bus_wr && sel_pd_data) begin
            port_d_data_ff <= i_bus_wdata[`FPIO_PD_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Direction registers
    // ------------------------------------------------------------------

    // Named reset value, so narrow ports can take a slice of it
    localparam logic [`FPIO_DATA_W-1:0] DIR_RST = `FPIO_DIR_RST;

    // Cleared by reset so every pin comes up as an input
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            port_a_direction_ff <= DIR_RST;
            port_b_direction_ff <= DIR_RST[`FPIO_PB_W-1:0];
            port_c_direction_ff <= DIR_RST;
            port_d_direction_ff <= DIR_RST[`FPIO_PD_W-1:0];
        end else if (i_bus_wr) begin
            if (sel_pa_dir) begin
                port_a_direction_ff <= i_bus_wdata;
            end
            if (sel_pb_dir) begin
                port_b_direction_ff <= i_bus_wdata[`FPIO_PB_W-1:0];
            end
            if (sel_pc_dir) begin
                port_c_direction_ff <= i_bus_wdata;
            end
            if (sel_pd_dir) begin
                port_d_direction_ff <= i_bus_wdata[`FPIO_PD_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read-back selection
    // ------------------------------------------------------------------

    // Output bits return the latch, input bits the pin
    assign rd_a = (port_a_direction_ff & port_a_data_ff) | (~port_a_direction_ff & i_pa_pin);
    assign rd_b = (port_b_direction_ff & port_b_data_ff) | (~port_b_direction_ff & i_pb_pin);
    assign rd_c = (port_c_direction_ff & port_c_data_ff) | (~port_c_direction_ff & i_pc_pin);
    assign rd_d = (port_d_direction_ff & port_d_data_ff) | (~port_d_direction_ff & i_pd_pin);

    // Narrow ports are zero-extended; unmapped addresses read zero
    always_comb begin
        nxt_rdata = `FPIO_RDATA_RST;
        if (sel_pa_data) begin
            nxt_rdata = rd_a;
        end else if (sel_pb_data) begin
            nxt_rdata = {{(`FPIO_DATA_W-`FPIO_PB_W){1'h0}}, rd_b};
        end else if (sel_pc_data) begin
            nxt_rdata = rd_c;
        end else if (sel_pd_data) begin
            nxt_rdata = {{(`FPIO_DATA_W-`FPIO_PD_W){1'h0}}, rd_d};
        end else if (sel_pa_dir) begin
            nxt_rdata = port_a_direction_ff;
        end else if (sel_pb_dir) begin
            nxt_rdata = {{(`FPIO_DATA_W-`FPIO_PB_W){1'h0}}, port_b_direction_ff};
        end else if (sel_pc_dir) begin
            nxt_rdata = port_c_direction_ff;
        end else if (sel_pd_dir) begin
            nxt_rdata = {{(`FPIO_DATA_W-`FPIO_PD_W){1'h0}}, port_d_direction_ff};
        end
    end

    // Read data is held until the next read strobe
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_bus_rdata <= `FPIO_RDATA_RST;
        end else if (i_bus_rd) begin
            o_bus_rdata <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Port D peripheral ownership
    // ------------------------------------------------------------------

    // Serial pins only ever pull low, so the peripheral drives
    // enable and leaves the level at zero
    always_comb begin
        pd_own = '0;
        pd_per_oe = '0;
        pd_per_val = '0;
        pd_own[`FPIO_PD_SCL_BIT] = i_cfg2_scl_sel;
        pd_per_oe[`FPIO_PD_SCL_BIT] = i_scl_drive_low;
        pd_own[`FPIO_PD_SDA_BIT] = i_cfg2_sda_sel;
        pd_per_oe[`FPIO_PD_SDA_BIT] = i_sda_drive_low;
        pd_own[`FPIO_PD_CLAMP_BIT] = i_clamp_sel;
        pd_per_oe[`FPIO_PD_CLAMP_BIT] = 1'h1;
        pd_per_val[`FPIO_PD_CLAMP_BIT] = i_clamp_val;
        pd_own[`FPIO_PD_SOG_BIT] = i_sog_sel;
    end

    // Pin levels handed to peripherals; inputs already synchronous
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_scl_in <= 1'h1;
            o_sda_in <= 1'h1;
            o_sync_on_green_input <= 1'h0;
        end else begin
            o_scl_in <= i_pd_pin[`FPIO_PD_SCL_BIT];
            o_sda_in <= i_pd_pin[`FPIO_PD_SDA_BIT];
            o_sync_on_green_input <= i_sog_sel & i_pd_pin[`FPIO_PD_SOG_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Port C function mux
    // ------------------------------------------------------------------
    fpio_pc_mux u_pc_mux (
        .i_pwm_sel(i_cfg1_pwm_sel),
        .i_pwm_val(i_pwm_val),
        .i_vsync_sel(i_cfg2_vsync_sel),
        .i_hsync_sel(i_cfg2_hsync_sel),
        .i_vertical_sync_out(i_vertical_sync_out),
        .i_horizontal_sync_out(i_horizontal_sync_out),
        .i_adc_sel(i_cfg2_adc_sel),
        .o_own(pc_own),
        .o_per_oe(pc_per_oe),
        .o_per_val(pc_per_val),
        .o_per_od(pc_per_od)
    );

    // ------------------------------------------------------------------
    // Pin output stages
    // ------------------------------------------------------------------

    // Port A: plain push-pull, no sharing
    fpio_pin_cell #(.WIDTH(`FPIO_PA_W)) u_pa_cell (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_latch(port_a_data_ff),
        .i_dir(port_a_direction_ff),
        .i_gpio_od('0),
        .i_own('0),
        .i_per_oe('0),
        .i_per_val('0),
        .i_per_od('0),
        .o_out(o_pa_out),
        .o_oe(o_pa_oe)
    );

    // Port B: upper four pins open drain
    fpio_pin_cell #(.WIDTH(`FPIO_PB_W)) u_pb_cell (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_latch(port_b_data_ff),
        .i_dir(port_b_direction_ff),
        .i_gpio_od(`FPIO_PB_OD_MASK),
        .i_own('0),
        .i_per_oe('0),
        .i_per_val('0),
        .i_per_od('0),
        .o_out(o_pb_out),
        .o_oe(o_pb_oe)
    );

    // Port C: push-pull as general I/O, shared with PWM, sync, converter
    fpio_pin_cell #(.WIDTH(`FPIO_PC_W)) u_pc_cell (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_latch(port_c_data_ff),
        .i_dir(port_c_direction_ff),
        .i_gpio_od('0),
        .i_own(pc_own),
        .i_per_oe(pc_per_oe),
        .i_per_val(pc_per_val),
        .i_per_od(pc_per_od),
        .o_out(o_pc_out),
        .o_oe(o_pc_oe)
    );

    // Port D: every pin open drain, in both owner cases
    fpio_pin_cell #(.WIDTH(`FPIO_PD_W)) u_pd_cell (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_latch(port_d_data_ff),
        .i_dir(port_d_direction_ff),
        .i_gpio_od(`FPIO_PD_OD_MASK),
        .i_own(pd_own),
        .i_per_oe(pd_per_oe),
        .i_per_val(pd_per_val),
        .i_per_od(`FPIO_PD_OD_MASK),
        .o_out(o_pd_out),
        .o_oe(o_pd_oe)
    );

endmodule

// file: fpio_props.sv
// Concurrent checks on the ports of the four-port parallel I/O block.
// Assumes binding to fpio_top; sees only its ports.
`timescale 1ns/1ps
module fpio_props (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic [7:0] i_bus_addr,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    input wire logic [7:0] i_bus_wdata,
    input wire logic [7:0] o_bus_rdata,
    input wire logic i_cfg2_hsync_sel,
    input wire logic i_horizontal_sync_out,
    input wire logic [3:0] i_cfg2_adc_sel,
    input wire logic [7:0] o_pa_oe,
    input wire logic [5:0] o_pb_out,
    input wire logic [5:0] o_pb_oe,
    input wire logic [7:0] o_pc_out,
    input wire logic [7:0] o_pc_oe,
    input wire logic [3:0] o_pd_out,
    input wire logic [3:0] o_pd_oe
);
    // ----
    // Bus and pin relations
    // ----
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    AST_OE_RST: assert property ($rose(i_rst_b) |-> o_pa_oe == 8'h00 && o_pc_oe == 8'h00)
        else $error("oe not cleared by reset");
    AST_DIR_A: assert property (i_bus_wr && i_bus_addr == 8'h04 ##1
        !(i_bus_wr && i_bus_addr == 8'h04) [*3] |-> o_pa_oe == $past(i_bus_wdata, 3))
        else $error("port A oe differs from direction");
    AST_UNMAPPED: assert property (i_bus_rd && i_bus_addr > 8'h07 |=> o_bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_B_UPPER: assert property (i_bus_rd && i_bus_addr[6:0] == 7'h05 |=> o_bus_rdata[7:6] == 2'h0)
        else $error("port B upper bits not zero");
    // Open drain: a driven bit may only pull low
    AST_B_OD: assert property ((o_pb_out[5:2] & o_pb_oe[5:2]) == 4'h0)
        else $error("port B open drain drives high");
    AST_D_OD: assert property ((o_pd_out & o_pd_oe) == 4'h0)
        else $error("port D open drain drives high");
    AST_ADC_REL: assert property (i_cfg2_adc_sel[0] [*2] |-> !o_pc_oe[2])
        else $error("converter pin still driven");
    AST_HSYNC: assert property (i_cfg2_hsync_sel [*2] |->
        o_pc_oe[7] && o_pc_out[7] == $past(i_horizontal_sync_out))
        else $error("sync output not on pin");
endmodule

bind fpio_top fpio_props u_props (.*);

// file: fpio_pins_model.sv
// Board side of all 26 pins: resolves drive against board levels.
// Assumes bits packed as {D, C, B, A}; released pins take i_ext.
`timescale 1ns/1ps
module fpio_pins_model (
    input wire logic [25:0] i_oe,
    input wire logic [25:0] i_out,
    input wire logic [25:0] i_ext,
    output logic [25:0] o_pin
);
    // Driven bits win, released ones show the board level or pull-up
    assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

// file: tb_top.sv
// Register-level tests of the four-port parallel I/O block.
// Assumes fpio_top, the pin model and the bound checker.
`timescale 1ns/1ps
module tb_top;
    logic i_clk_sys = 0, i_rst_b = 0, i_bus_wr = 0, i_bus_rd = 0;
    logic [7:0] i_bus_addr = '0, i_bus_wdata = '0, o_bus_rdata, i_cfg1_pwm_sel = '0;
    logic [7:0] i_pwm_val = '0, o_pa_out, o_pa_oe, o_pc_out, o_pc_oe;
    logic [3:0] i_cfg2_adc_sel = '0, o_pd_out, o_pd_oe;
    logic [5:0] o_pb_out, o_pb_oe;
    logic i_cfg2_vsync_sel = 0, i_cfg2_hsync_sel = 0, i_cfg2_scl_sel = 0, i_cfg2_sda_sel = 0;
    logic i_clamp_sel = 0, i_sog_sel = 0, i_vertical_sync_out = 0, i_horizontal_sync_out = 0;
    logic i_scl_drive_low = 0, i_sda_drive_low = 0, i_clamp_val = 0;
    logic o_scl_in, o_sda_in, o_sync_on_green_input;
    wire logic [7:0] i_pa_pin, i_pc_pin;
    wire logic [5:0] i_pb_pin;
    wire logic [3:0] i_pd_pin;
    logic [25:0] ext = {4'hF, 8'hFF, 6'h3F, 8'hC3};
    logic [7:0] msk [8] = '{8'hFF, 8'h3F, 8'hFF, 8'h0F, 8'hFF, 8'h3F, 8'hFF, 8'h0F};
    int err_total = 0;
    int cmp_count = 0;

    fpio_top uut (.*);
    fpio_pins_model pins (.i_oe({o_pd_oe, o_pc_oe, o_pb_oe, o_pa_oe}),
        .i_out({o_pd_out, o_pc_out, o_pb_out, o_pa_out}), .i_ext(ext),
        .o_pin({i_pd_pin, i_pc_pin, i_pb_pin, i_pa_pin}));

    initial forever #5 i_clk_sys = ~i_clk_sys;

    // ----
    // Bus tasks and comparison
    // ----
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_bus_addr <= a;
        i_bus_wdata <= d;
        i_bus_wr <= 1;
        @(posedge i_clk_sys);
        i_bus_wr <= 0;
    endtask
    // Data lands on the take edge, so look one edge later
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_bus_addr <= a;
        i_bus_rd <= 1;
        @(posedge i_clk_sys);
        i_bus_rd <= 0;
        @(posedge i_clk_sys);
        chk(o_bus_rdata, e);
    endtask
    task automatic test_done;
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Generous bound; the sequence needs about a hundred cycles
    initial begin
        repeat (5000) @(posedge i_clk_sys);
        err_total++;
        test_done;
    end

    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_rst_b <= 1;
        for (int i = 4; i < 8; i++) rd(8'(i), 8'h00);
        wr(8'h00, 8'h5A);
        rd(8'h00, 8'hC3);
        wr(8'h04, 8'h0F);
        rd(8'h00, 8'hCA);
        chk(o_pa_oe, 8'h0F);
        chk(o_pa_out & 8'h0F, 8'h0A);
        // Reset in mid-run keeps the latch
        @(posedge i_clk_sys);
        i_rst_b <= 0;
        @(posedge i_clk_sys);
        i_rst_b <= 1;
        rd(8'h04, 8'h00);
        wr(8'h04, 8'hFF);
        rd(8'h00, 8'h5A);
        for (int i = 0; i < 9; i++) wr(8'(i), 8'hFF);
        foreach (msk[i]) rd(8'(i), msk[i]);
        rd(8'h08, 8'h00);
        wr(8'h01, 8'h00);
        rd(8'h01, 8'h00);
        chk(8'(o_pb_oe), 8'h3F);
        wr(8'h01, 8'h3C);
        rd(8'h01, 8'h3C);
        chk(8'(o_pb_oe), 8'h03);
        // Port C sharing with direction all input
        wr(8'h06, 8'h00);
        i_cfg1_pwm_sel <= 8'h14;
        i_pwm_val <= 8'h10;
        i_cfg2_adc_sel <= 4'h1;
        i_cfg2_hsync_sel <= 1;
        i_cfg2_vsync_sel <= 1;
        i_horizontal_sync_out <= 1;
        wr(8'h07, 8'h00);
        i_cfg2_scl_sel <= 1;
        i_scl_drive_low <= 1;
        i_clamp_sel <= 1;
        i_sog_sel <= 1;
        repeat (3) @(posedge i_clk_sys);
        chk(o_pc_oe, 8'hD0);
        chk(o_pc_out & 8'hD0, 8'h90);
        chk(8'(o_pd_oe), 8'h05);
        chk(8'(o_scl_in), 8'h00);
        chk(8'(o_sync_on_green_input), 8'h01);
        chk(8'(o_sda_in), 8'h01);
        // D3 set to drive low as GPIO must stay released while sync-on-green owns it
        wr(8'h03, 8'h00);
        wr(8'h07, 8'h08);
        // C0 and C1 PWM only pull low; serial data pulls D1, clamp releases D2
        i_cfg1_pwm_sel <= 8'h17;
        i_pwm_val <= 8'h12;
        i_cfg2_sda_sel <= 1;
        i_sda_drive_low <= 1;
        i_clamp_val <= 1;
        repeat (3) @(posedge i_clk_sys);
        chk(o_pc_oe, 8'hD1);
        chk(o_pc_out & 8'h03, 8'h00);
        chk(8'(o_pd_oe), 8'h03);
        chk(8'(o_pd_out), 8'h00);
        chk(8'(o_sda_in), 8'h00);
        chk(8'(o_sync_on_green_input), 8'h01);
        test_done;
    end
endmodule
